// *** src/bcda_defs.svh ***
// Contract
// - data contact detect: source current into D+, pull-down on D-.
// - primary/secondary: force voltage one line, sink other, ADC samples it.
// - voltage source and current sink only in detection or CDP.
// - CDP: when D+ reaches trigger, drive D- at that level until D+ low.
// - CDP keeps voltage source and current sink enabled; code keeps the sink on and enables the source only while replying.
// - DCP shorted: connect D+ to D- through short resistance.
// - divider mode: bias voltage on both lines via own output resistance.
// - 1.2-V mode: low bias on D- via resistance, plus D+/D- short.
// - auto DCP picks DCP, divider or 1.2-V by what device detects.
// - auto DCP changes scheme without VBUS discharge or removal.
// - ADC results reach internal logic only, never an external path; code also returns the last sample as bus read data at the adc offset.
`ifndef BCDA_DEFS_SVH
`define BCDA_DEFS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define BCDA_OFS_CTRL    12'h000
`define BCDA_OFS_STATUS  12'h004
`define BCDA_OFS_THRESH  12'h008
`define BCDA_OFS_ADC     12'h00C

// ----------------------------------------
// field positions
// ----------------------------------------
`define BCDA_CTRL_MODE_LSB   0
`define BCDA_CTRL_MODE_MSB   2
`define BCDA_CTRL_LINE_BIT   3
`define BCDA_THR_LO_LSB      0
`define BCDA_THR_LO_MSB      9
`define BCDA_THR_HI_LSB      16
`define BCDA_THR_HI_MSB      25
`define BCDA_RESP_OKAY       2'h0
`define BCDA_RESP_SLVERR     2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define BCDA_CTRL_RST    32'h0000_0000
`define BCDA_THR_LO_RST  10'h0B8
`define BCDA_THR_HI_RST  10'h100

`endif

// *** src/bcda_pkg.sv ***
package bcda_pkg;
  // scheme picked by software
  typedef enum logic [2:0] {
    BCDA_IDLE, BCDA_DCD, BCDA_PRISEC, BCDA_CDP,
    BCDA_DCP, BCDA_DIV, BCDA_LOWV, BCDA_AUTO
  } bcda_mode_t;
  // scheme applied by auto mode
  typedef enum logic [1:0] {
    BCDA_AUTO_DCP, BCDA_AUTO_DIV, BCDA_AUTO_LOWV
  } bcda_auto_t;
endpackage : bcda_pkg

// *** src/bcda_axil.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bcda_defs.svh"
module bcda_axil (
  input  wire logic        clk,       // clock
  input  wire logic        rst,       // sync reset
  input  wire logic        ce,        // clock enable
  input  wire logic [11:0] awaddr,    // write address
  input  wire logic        awvalid,   // write address valid
  output logic             awready,   // write address ready
  input  wire logic [31:0] wdata,     // write data
  input  wire logic [3:0]  wstrb,     // byte strobes
  input  wire logic        wvalid,    // write data valid
  output logic             wready,    // write data ready
  output logic [1:0]       bresp,     // write response
  output logic             bvalid,    // response valid
  input  wire logic        bready,    // response ready
  input  wire logic [11:0] araddr,    // read address
  input  wire logic        arvalid,   // read address valid
  output logic             arready,   // read address ready
  output logic [31:0]      rdata,     // read data
  output logic [1:0]       rresp,     // read response
  output logic             rvalid,    // read valid
  input  wire logic        rready,    // read ready
  output logic             wr_en,     // write strobe to regs
  output logic [11:0]      wr_addr,   // write address to regs
  output logic [31:0]      wr_data,   // write data to regs
  output logic [3:0]       wr_strb,   // strobes to regs
  input  wire logic        wr_ok,     // address writable
  output logic [11:0]      rd_addr,   // read address to regs
  input  wire logic [31:0] rd_data,   // read data from regs
  input  wire logic        rd_ok      // address mapped
);
  logic        aw_have_r, w_have_r;
  logic [11:0] aw_r;
  logic [31:0] w_r;
  logic [3:0]  s_r;

  // ----------------------------------------
  // write channel: address and data in either order
  // ----------------------------------------
  assign awready = !aw_have_r && !bvalid;
  assign wready  = !w_have_r && !bvalid;
  assign wr_en   = aw_have_r && w_have_r && !bvalid && ce;
  assign wr_addr = aw_r;
  assign wr_data = w_r;
  assign wr_strb = s_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_r      <= 12'h000;
      w_r       <= 32'h0000_0000;
      s_r       <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `BCDA_RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_r      <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_r      <= wdata;
        s_r      <= wstrb;
      end
      if (wr_en) begin
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `BCDA_RESP_OKAY : `BCDA_RESP_SLVERR;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read channel: one cycle to data
  // ----------------------------------------
  assign arready = !rvalid;
  assign rd_addr = araddr;

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `BCDA_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_ok ? rd_data : 32'h0000_0000;
        rresp  <= rd_ok ? `BCDA_RESP_OKAY : `BCDA_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : bcda_axil
`default_nettype wire

// *** src/bcda_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module bcda_decode
  import bcda_pkg::*;
(
  input  wire bcda_mode_t mode,        // scheme in force
  input  wire bcda_auto_t auto_sel,    // auto-mode pick
  input  wire logic       cdp_drive,   // cdp reply active
  output logic [6:0]      en           // element enables
);
  // one enable vector per scheme; only one scheme at a time
  // bit: 0 dp_src 1 dm_pd 2 vsrc 3 isnk 4 short 5 div 6 lowv
  always_comb begin
    en = 7'h00;
    case (mode)
      BCDA_DCD:    en = 7'h03;
      BCDA_PRISEC: en = 7'h0C;
      BCDA_CDP:    en = cdp_drive ? 7'h0C : 7'h08;
      BCDA_DCP:    en = 7'h10;
      BCDA_DIV:    en = 7'h20;
      BCDA_LOWV:   en = 7'h50;
      BCDA_AUTO: begin
        case (auto_sel)
          BCDA_AUTO_DIV:  en = 7'h20;
          BCDA_AUTO_LOWV: en = 7'h50;
          default:        en = 7'h10;
        endcase
      end
      default:     en = 7'h00;
    endcase
  end
endmodule : bcda_decode
`default_nettype wire

// *** src/bcda_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bcda_defs.svh"
module bcda_top
  import bcda_pkg::*;
#(
  parameter int ADC_W = 10                // adc result width
)(
  input  wire logic             REF_CLK,     // 10 MHz clock
  input  wire logic             RESET,       // sync reset, high
  input  wire logic             CLK_EN,      // freezes state when low
  input  wire logic [11:0]      S_AXI_AWADDR,  // write address
  input  wire logic             S_AXI_AWVALID, // write address valid
  output logic                  S_AXI_AWREADY, // write address ready
  input  wire logic [31:0]      S_AXI_WDATA,   // write data
  input  wire logic [3:0]       S_AXI_WSTRB,   // byte strobes
  input  wire logic             S_AXI_WVALID,  // write data valid
  output logic                  S_AXI_WREADY,  // write data ready
  output logic [1:0]            S_AXI_BRESP,   // write response
  output logic                  S_AXI_BVALID,  // response valid
  input  wire logic             S_AXI_BREADY,  // response ready
  input  wire logic [11:0]      S_AXI_ARADDR,  // read address
  input  wire logic             S_AXI_ARVALID, // read address valid
  output logic                  S_AXI_ARREADY, // read address ready
  output logic [31:0]           S_AXI_RDATA,   // read data
  output logic [1:0]            S_AXI_RRESP,   // read response
  output logic                  S_AXI_RVALID,  // read valid
  input  wire logic             S_AXI_RREADY,  // read ready
  input  wire logic [ADC_W-1:0] ADC_RESULT,    // internal adc sample
  input  wire logic             ADC_VALID,     // sample strobe
  output logic                  ADC_SEL_DMINUS, // adc on D- (else D+)
  output logic                  DPLUS_SOURCE_CURRENT, // current into D+
  output logic                  DMINUS_PULLDOWN_RES,  // D- pull-down
  output logic                  LINE_VOLTAGE_SOURCE,  // voltage source
  output logic                  LINE_CURRENT_SINK,    // current sink
  output logic                  FORCE_ON_DMINUS,  // source on D-, sink D+
  output logic                  DCP_SHORT_RES,    // D+ to D- short
  output logic                  DIVIDER_BIAS_EN,  // divider bias, both
  output logic                  LOW_BIAS_EN,      // low bias on D-
  input  wire logic             AUTO_SEEN_DIV,    // device wants divider
  input  wire logic             AUTO_SEEN_LOWV    // device wants low bias
);
  logic        wr_en, wr_ok, rd_ok;
  logic [11:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  logic [31:0] ctrl_r;
  logic [ADC_W-1:0] thr_lo_r, thr_hi_r, adc_r;
  logic        cdp_drive_r, cdp_drive_nxt;
  bcda_auto_t  auto_r, auto_nxt;
  bcda_mode_t  mode;
  logic [6:0]  en;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  bcda_axil u_bus (
    .clk     (REF_CLK),
    .rst     (RESET),
    .ce      (CLK_EN),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // status and adc are read only; writes there answer slverr
  assign wr_ok = (wr_addr == `BCDA_OFS_CTRL) ||
                 (wr_addr == `BCDA_OFS_THRESH);

  // control and threshold storage; ctrl byte 0 on strobe 0, each threshold only with both its byte strobes
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_r   <= `BCDA_CTRL_RST;
      thr_lo_r <= ADC_W'(`BCDA_THR_LO_RST);
      thr_hi_r <= ADC_W'(`BCDA_THR_HI_RST);
    end else if (CLK_EN && wr_en) begin
      if (wr_addr == `BCDA_OFS_CTRL && wr_strb[0])
        ctrl_r[7:0] <= wr_data[7:0];
      if (wr_addr == `BCDA_OFS_THRESH) begin
        if (wr_strb[0] && wr_strb[1])
          thr_lo_r <= wr_data[`BCDA_THR_LO_LSB +: ADC_W];
        if (wr_strb[2] && wr_strb[3])
          thr_hi_r <= wr_data[`BCDA_THR_HI_LSB +: ADC_W];
      end
    end
  end

  assign mode = bcda_mode_t'(ctrl_r[`BCDA_CTRL_MODE_MSB:`BCDA_CTRL_MODE_LSB]);

  // read mux; adc sample is an internal register, reaching a pin only as bus read data at the adc offset
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `BCDA_OFS_CTRL:   rd_data = ctrl_r;
      `BCDA_OFS_STATUS: rd_data = {25'h0, en[6:4], auto_r, cdp_drive_r,
                                   en[3]};
      `BCDA_OFS_THRESH: begin
        rd_data[`BCDA_THR_LO_LSB +: ADC_W] = thr_lo_r;
        rd_data[`BCDA_THR_HI_LSB +: ADC_W] = thr_hi_r;
      end
      `BCDA_OFS_ADC:    rd_data[ADC_W-1:0] = adc_r;
      default:          rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------
  // adc capture
  // ----------------------------------------
  // samples land in an internal register only
  always_ff @(posedge REF_CLK) begin
    if (RESET)
      adc_r <= '0;
    else if (CLK_EN && ADC_VALID)
      adc_r <= ADC_RESULT;
  end

  // ----------------------------------------
  // cdp reply: hysteresis on D+
  // ----------------------------------------
  // high threshold arms the reply, low threshold releases it
  always_comb begin
    cdp_drive_nxt = cdp_drive_r;
    if (mode != BCDA_CDP)
      cdp_drive_nxt = 1'b0;
    else if (ADC_VALID && ADC_RESULT >= thr_hi_r)
      cdp_drive_nxt = 1'b1;
    else if (ADC_VALID && ADC_RESULT < thr_lo_r)
      cdp_drive_nxt = 1'b0;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET)
      cdp_drive_r <= 1'b0;
    else if (CLK_EN)
      cdp_drive_r <= cdp_drive_nxt;
  end

  // ----------------------------------------
  // auto dcp selection
  // ----------------------------------------
  // switches on the fly; vbus is never touched by this block
  always_comb begin
    auto_nxt = auto_r;
    if (mode != BCDA_AUTO)
      auto_nxt = BCDA_AUTO_DCP;
    else if (AUTO_SEEN_LOWV)
      auto_nxt = BCDA_AUTO_LOWV;
    else if (AUTO_SEEN_DIV)
      auto_nxt = BCDA_AUTO_DIV;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET)
      auto_r <= BCDA_AUTO_DCP;
    else if (CLK_EN)
      auto_r <= auto_nxt;
  end

  // ----------------------------------------
  // element decode and registered enables
  // ----------------------------------------
  bcda_decode u_dec (
    .mode      (mode),
    .auto_sel  (auto_r),
    .cdp_drive (cdp_drive_r),
    .en        (en)
  );

  // adc looks at the sensed line: D- in detection by default, D+ in cdp
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      DPLUS_SOURCE_CURRENT <= 1'b0;
      DMINUS_PULLDOWN_RES  <= 1'b0;
      LINE_VOLTAGE_SOURCE  <= 1'b0;
      LINE_CURRENT_SINK    <= 1'b0;
      DCP_SHORT_RES        <= 1'b0;
      DIVIDER_BIAS_EN      <= 1'b0;
      LOW_BIAS_EN          <= 1'b0;
      FORCE_ON_DMINUS      <= 1'b0;
      ADC_SEL_DMINUS       <= 1'b0;
    end else if (CLK_EN) begin
      DPLUS_SOURCE_CURRENT <= en[0];
      DMINUS_PULLDOWN_RES  <= en[1];
      LINE_VOLTAGE_SOURCE  <= en[2];
      LINE_CURRENT_SINK    <= en[3];
      DCP_SHORT_RES        <= en[4];
      DIVIDER_BIAS_EN      <= en[5];
      LOW_BIAS_EN          <= en[6];
      // cdp forces D-, senses D+; detection line picked by software
      FORCE_ON_DMINUS <= (mode == BCDA_CDP) ? 1'b1
                         : ctrl_r[`BCDA_CTRL_LINE_BIT];
      ADC_SEL_DMINUS  <= (mode == BCDA_CDP) ? 1'b0
                         : !ctrl_r[`BCDA_CTRL_LINE_BIT];
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  // detection elements
  a_idle_all_off: assert property (
    CLK_EN && mode == BCDA_IDLE |=> !DPLUS_SOURCE_CURRENT &&
      !LINE_VOLTAGE_SOURCE && !DCP_SHORT_RES && !DIVIDER_BIAS_EN
      && !LOW_BIAS_EN && !DMINUS_PULLDOWN_RES && !LINE_CURRENT_SINK)
    else $error("element left on while idle");
  a_dcd_elements: assert property (
    CLK_EN && mode == BCDA_DCD |=> DPLUS_SOURCE_CURRENT &&
      DMINUS_PULLDOWN_RES && !LINE_VOLTAGE_SOURCE)
    else $error("contact detect elements wrong");
  a_dcd_only: assert property (
    CLK_EN && mode != BCDA_DCD |=> !DPLUS_SOURCE_CURRENT)
    else $error("contact detect source on outside detection");
  a_src_only_det: assert property (
    LINE_VOLTAGE_SOURCE |-> $past(mode) == BCDA_PRISEC ||
      $past(mode) == BCDA_CDP || !$past(CLK_EN))
    else $error("voltage source on outside detection");
  a_prisec_path: assert property (
    CLK_EN && mode == BCDA_PRISEC |=> LINE_VOLTAGE_SOURCE &&
      LINE_CURRENT_SINK && ADC_SEL_DMINUS != FORCE_ON_DMINUS)
    else $error("detection path wrong");

  // cdp reply: arm above trigger, drop below release, two cycles late
  sequence s_dplus_high;
    CLK_EN && mode == BCDA_CDP && ADC_VALID && ADC_RESULT >= thr_hi_r;
  endsequence
  sequence s_dplus_low;
    CLK_EN && mode == BCDA_CDP && ADC_VALID && ADC_RESULT < thr_lo_r
      && ADC_RESULT < thr_hi_r;
  endsequence
  sequence s_cdp_next;
    CLK_EN && mode == BCDA_CDP;
  endsequence
  a_cdp_reply: assert property (
    s_dplus_high ##1 s_cdp_next |=> LINE_VOLTAGE_SOURCE && FORCE_ON_DMINUS)
    else $error("cdp reply not driven");
  a_cdp_release: assert property (
    s_dplus_low ##1 s_cdp_next |=> !LINE_VOLTAGE_SOURCE)
    else $error("cdp reply held after release");
  a_cdp_no_early: assert property (
    CLK_EN && mode == BCDA_CDP && !cdp_drive_r |=> !LINE_VOLTAGE_SOURCE)
    else $error("cdp reply before trigger");
  a_cdp_sink: assert property (
    CLK_EN && mode == BCDA_CDP |=> LINE_CURRENT_SINK && FORCE_ON_DMINUS
      && !ADC_SEL_DMINUS)
    else $error("cdp sink off");

  // advertisements
  a_dcp_short: assert property (
    CLK_EN && mode == BCDA_DCP |=> DCP_SHORT_RES &&
      !DIVIDER_BIAS_EN && !LOW_BIAS_EN)
    else $error("dcp short wrong");
  a_div_bias: assert property (
    CLK_EN && mode == BCDA_DIV |=> DIVIDER_BIAS_EN && !DCP_SHORT_RES)
    else $error("divider bias wrong");
  a_lowv_bias: assert property (
    CLK_EN && mode == BCDA_LOWV |=> LOW_BIAS_EN && DCP_SHORT_RES)
    else $error("low bias wrong");
  a_one_scheme: assert property (
    !(DIVIDER_BIAS_EN && DCP_SHORT_RES) &&
      !(DPLUS_SOURCE_CURRENT && LINE_VOLTAGE_SOURCE))
    else $error("two schemes on the lines");

  // auto pick lands two cycles after the classifier speaks
  sequence s_auto_on;
    CLK_EN && mode == BCDA_AUTO;
  endsequence
  a_auto_pick: assert property (
    CLK_EN && mode == BCDA_AUTO && AUTO_SEEN_LOWV ##1 s_auto_on
      |=> LOW_BIAS_EN)
    else $error("auto mode did not apply low bias");
  a_auto_div: assert property (
    CLK_EN && mode == BCDA_AUTO && AUTO_SEEN_DIV && !AUTO_SEEN_LOWV
      ##1 s_auto_on |=> DIVIDER_BIAS_EN)
    else $error("auto mode did not apply divider");
  a_auto_exit: assert property (
    CLK_EN && mode != BCDA_AUTO |=> auto_r == BCDA_AUTO_DCP)
    else $error("auto pick kept outside auto mode");
  // each valid sample lands in the internal register a cycle later
  a_adc_capture: assert property (
    CLK_EN && ADC_VALID |=> adc_r == $past(ADC_RESULT))
    else $error("adc sample not captured");
endmodule : bcda_top
`default_nettype wire

// *** verif/bcda_usb_dev.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// attached usb device seen through the adc
// ----------------------------------------
module bcda_usb_dev #(
  parameter int ADC_W  = 10,            // sample width
  parameter int PERIOD = 4              // cycles between samples
)(
  input  wire logic             clk,        // clock
  input  wire logic             rst,        // sync reset
  input  wire logic             sel_dminus, // adc on D- (else D+)
  input  wire logic [ADC_W-1:0] dp_lvl,     // D+ level, host pull-downs
  input  wire logic [ADC_W-1:0] dm_lvl,     // D- level
  input  wire logic             want_div,   // device wants divider
  input  wire logic             want_lowv,  // device wants 1.2 V
  output logic [ADC_W-1:0]      adc_result, // sample
  output logic                  adc_valid,  // sample strobe
  output logic                  seen_div,   // classifier: divider
  output logic                  seen_lowv   // classifier: 1.2 V
);
  int cnt_r;

  // periodic sample; data toggles between strobes so stale values never pass
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r      <= 0;
      adc_valid  <= 1'b0;
      adc_result <= '0;
    end else begin
      cnt_r     <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      adc_valid <= (cnt_r == 0);
      if (cnt_r == 0)
        adc_result <= sel_dminus ? dm_lvl : dp_lvl;
      else
        adc_result <= ~adc_result;
    end
  end

  // classifier levels lag the device by one cycle
  always_ff @(posedge clk) begin
    seen_div  <= rst ? 1'b0 : want_div;
    seen_lowv <= rst ? 1'b0 : want_lowv;
  end
endmodule : bcda_usb_dev
`default_nettype wire

// *** verif/bc12_charger_detect_advertise_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bcda_defs.svh"
module bc12_charger_detect_advertise_bench;
  logic        clk = 0, rst = 1, clk_en = 1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0]  wstrb = '0;
  logic        awready, wready, bvalid, arready, rvalid, adc_valid, adc_sel;
  logic        seen_div, seen_lowv, want_div = 0, want_lowv = 0, ln;
  logic [1:0]  bresp, rresp, rs;
  logic [9:0]  adc_res, dp_lvl = '0, dm_lvl = '0;
  wire  [7:0]  en;
  int          miscompares = 0, n_compared = 0;

  always #50 clk = ~clk;

  bcda_top dut (.REF_CLK(clk), .RESET(rst), .CLK_EN(clk_en),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ADC_RESULT(adc_res),
    .ADC_VALID(adc_valid), .ADC_SEL_DMINUS(adc_sel),
    .DPLUS_SOURCE_CURRENT(en[0]), .DMINUS_PULLDOWN_RES(en[1]),
    .LINE_VOLTAGE_SOURCE(en[2]), .LINE_CURRENT_SINK(en[3]),
    .FORCE_ON_DMINUS(en[4]), .DCP_SHORT_RES(en[5]),
    .DIVIDER_BIAS_EN(en[6]), .LOW_BIAS_EN(en[7]),
    .AUTO_SEEN_DIV(seen_div), .AUTO_SEEN_LOWV(seen_lowv));

  bcda_usb_dev #(.ADC_W(10), .PERIOD(4)) dev (.clk(clk), .rst(rst),
    .sel_dminus(adc_sel), .dp_lvl(dp_lvl), .dm_lvl(dm_lvl),
    .want_div(want_div), .want_lowv(want_lowv), .adc_result(adc_res),
    .adc_valid(adc_valid), .seen_div(seen_div), .seen_lowv(seen_lowv));

  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  // enables as {low,div,short,force,sink,vsrc,pulldown,isrc}
  // force follows the line bit in every scheme but cdp
  function automatic logic [7:0] exp_en(input logic [2:0] m, input logic l);
    logic [7:0] b;
    case (m)
      3'd1:    b = 8'b0000_0011;
      3'd2:    b = 8'b0000_1100;
      3'd4:    b = 8'b0010_0000;
      3'd5:    b = 8'b0100_0000;
      3'd6:    b = 8'b1010_0000;
      default: b = 8'h00;
    endcase
    return b | {3'b000, l, 4'h0};
  endfunction : exp_en

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // handshakes judged mid-cycle, acted on at the following rising edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic ad, wd, bd, ah, wh, bh;
    ad = 0; wd = 0; bd = 0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= s; wvalid <= 1;
    bready <= 1;
    while (!bd) begin
      @(negedge clk);
      ah = awvalid & awready; wh = wvalid & wready; bh = bready & bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) begin awvalid <= 0; ad = 1; end
      if (wh) begin wvalid <= 0; wd = 1; end
      if (bh) begin bready <= 0; bd = 1; end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ah, rh, rd_done;
    rd_done = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!rd_done) begin
      @(negedge clk);
      ah = arvalid & arready; rh = rready & rvalid; d = rdata; r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 0;
      if (rh) begin rready <= 0; rd_done = 1; end
    end
  endtask : axi_rd

  // enables follow ctrl one cycle after the write lands
  task automatic set_mode(input logic [2:0] m, input logic l);
    axi_wr(`BCDA_OFS_CTRL, {28'h0, l, m}, 4'hF, rs);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : set_mode

  task automatic wait_en(input logic [7:0] e);
    for (int i = 0; i < 20 && en !== e; i++) @(negedge clk);
    chk("enables", {24'h0, e}, {24'h0, en});
  endtask : wait_en

  task automatic finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hC85E));
    repeat (8) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("reset outputs", 32'h0, {23'h0, adc_sel, en});
    axi_rd(`BCDA_OFS_CTRL, rd, rs);
    chk("ctrl reset", `BCDA_CTRL_RST, rd);
    axi_rd(`BCDA_OFS_THRESH, rd, rs);
    chk("thresh reset", 32'h0100_00B8, rd);
    $display("test reset done");

    // every fixed scheme except cdp, twice, back to back, then idle again
    for (int k = 0; k < 14; k++) begin
      if (k % 7 == 3) continue;
      ln = 1'($urandom);
      set_mode(3'(k % 7), ln);
      chk("scheme", {24'h0, exp_en(3'(k % 7), ln)},
          {24'h0, en});
      if (k % 7 == 2) chk("adc line", {31'h0, ~ln}, {31'h0, adc_sel});
    end
    set_mode(3'd0, 1'b0);
    chk("idle enables", 32'h0, {24'h0, en});
    $display("test schemes done");

    // partial strobes and refused places
    set_mode(3'd4, 1'b0);
    axi_wr(`BCDA_OFS_CTRL, 32'h5, 4'hE, rs);
    repeat (3) @(negedge clk);
    chk("ctrl no byte0", {24'h0, exp_en(3'd4, 0)}, {24'h0, en});
    axi_wr(`BCDA_OFS_STATUS, 32'hFF, 4'hF, rs);
    chk("status write resp", {30'h0, `BCDA_RESP_SLVERR}, {30'h0, rs});
    axi_rd(12'h010, rd, rs);
    chk("unmapped resp", {30'h0, `BCDA_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    axi_wr(`BCDA_OFS_THRESH, 32'h0180_0000, 4'hC, rs);
    axi_rd(`BCDA_OFS_THRESH, rd, rs);
    chk("thresh upper", 32'h0180_00B8, rd);
    axi_wr(`BCDA_OFS_THRESH, 32'h0100_00B8, 4'hF, rs);
    $display("test registers done");

    // cdp: trigger boundary, reply, release
    set_mode(3'd3, 1'b0);
    chk("cdp sink", 32'h1, {31'h0, en[3]});
    chk("cdp adc line", 32'h0, {31'h0, adc_sel});
    @(posedge clk) dp_lvl <= 10'h0FF;
    repeat (20) @(negedge clk);
    chk("cdp below trigger", 32'h0, {31'h0, en[2]});
    @(posedge clk) dp_lvl <= 10'($urandom_range(10'h100, 10'h3FF));
    for (int i = 0; i < 20 && en[2] !== 1'b1; i++) @(negedge clk);
    chk("cdp reply", 32'hF, {28'h0, en[4:2], 1'b1});
    axi_rd(`BCDA_OFS_STATUS, rd, rs);
    chk("cdp reply flag", 32'h1, {31'h0, rd[1]});
    @(posedge clk) dp_lvl <= 10'($urandom_range(10'h000, 10'h0B7));
    for (int i = 0; i < 20 && en[2] !== 1'b0; i++) @(negedge clk);
    chk("cdp release", 32'h2, {30'h0, en[3:2]});
    $display("test cdp done");

    // auto: pick follows the device, sticky, reset on leaving
    set_mode(3'd7, 1'b0);
    wait_en(exp_en(3'd4, 0));
    @(posedge clk) begin clk_en <= 0; want_div <= 1; end
    repeat (6) @(negedge clk);
    chk("frozen", {24'h0, exp_en(3'd4, 0)}, {24'h0, en});
    @(posedge clk) clk_en <= 1;
    wait_en(exp_en(3'd5, 0));
    @(posedge clk) want_lowv <= 1;
    wait_en(exp_en(3'd6, 0));
    @(posedge clk) begin want_div <= 0; want_lowv <= 0; end
    repeat (10) @(negedge clk);
    chk("auto sticky", {24'h0, exp_en(3'd6, 0)}, {24'h0, en});
    set_mode(3'd4, 1'b0);
    set_mode(3'd7, 1'b0);
    wait_en(exp_en(3'd4, 0));
    $display("test auto done");
    finish_test();
  end
endmodule : bc12_charger_detect_advertise_bench
`default_nettype wire
